// ---- pkg/line_ctrl_pkg.sv ----
// package: register map, reset values and limits of the line controller
package line_ctrl_pkg;
    localparam int unsigned LINES = 32;
    localparam int unsigned AW = 8;
    localparam logic [7:0] OFF_OWN_EN = 8'h00;
    localparam logic [7:0] OFF_OWN_DIS = 8'h04;
    localparam logic [7:0] OFF_OWN_ST = 8'h08;
    localparam logic [7:0] OFF_OE_EN = 8'h10;
    localparam logic [7:0] OFF_OE_DIS = 8'h14;
    localparam logic [7:0] OFF_OE_ST = 8'h18;
    localparam logic [7:0] OFF_FLT_EN = 8'h20;
    localparam logic [7:0] OFF_FLT_DIS = 8'h24;
    localparam logic [7:0] OFF_FLT_ST = 8'h28;
    localparam logic [7:0] OFF_OUT_SET = 8'h30;
    localparam logic [7:0] OFF_OUT_CLR = 8'h34;
    localparam logic [7:0] OFF_OUT_DATA = 8'h38;
    localparam logic [7:0] OFF_PIN_ST = 8'h3c;
    localparam logic [7:0] OFF_CHG_EN = 8'h40;
    localparam logic [7:0] OFF_CHG_DIS = 8'h44;
    localparam logic [7:0] OFF_CHG_MASK = 8'h48;
    localparam logic [7:0] OFF_CHG_ST = 8'h4c;
    localparam logic [7:0] OFF_MD_EN = 8'h50;
    localparam logic [7:0] OFF_MD_DIS = 8'h54;
    localparam logic [7:0] OFF_MD_ST = 8'h58;
    localparam logic [7:0] OFF_PU_DIS = 8'h60;
    localparam logic [7:0] OFF_PU_EN = 8'h64;
    localparam logic [7:0] OFF_PU_ST = 8'h68;
    localparam logic [7:0] OFF_SEL_A = 8'h70;
    localparam logic [7:0] OFF_SEL_B = 8'h74;
    localparam logic [7:0] OFF_SEL_ST = 8'h78;
    localparam logic [7:0] OFF_OW_EN = 8'ha0;
    localparam logic [7:0] OFF_OW_DIS = 8'ha4;
    localparam logic [7:0] OFF_OW_ST = 8'ha8;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_OWN = 32'hffff_ffff;
    localparam logic [31:0] RST_HAS_PERIPH = 32'hffff_ffff;
    localparam int unsigned IRQ_SRC_MIN = 2;
    localparam int unsigned IRQ_SRC_MAX = 31;
    localparam int unsigned IRQ_SRC_DEF = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- pkg/line_if.sv ----
// interface: sampled pin levels and change pulses between top and sampler
`timescale 1ns/1ps
`default_nettype none
interface line_if;
    logic                                  clk;
    logic                                  rst_n;
    logic                                  ce;
    logic                                  sample_en;
    logic [line_ctrl_pkg::LINES-1:0]       pin_in;
    logic [line_ctrl_pkg::LINES-1:0]       filt_en;
    logic [line_ctrl_pkg::LINES-1:0]       level;
    logic [line_ctrl_pkg::LINES-1:0]       change;
    modport ctrl (output clk, rst_n, ce, sample_en, pin_in, filt_en,
                  input level, change);
    modport sampler (input clk, rst_n, ce, sample_en, pin_in, filt_en,
                     output level, change);
endinterface
`default_nettype wire

// ---- src/line_sampler.sv ----
// module: per-line input sampling, glitch filter and change detection
`timescale 1ns/1ps
`default_nettype none
module line_sampler
(
    line_if.sampler lif
);
    genvar i;
    // one slice per line, same bit index everywhere
    generate
        for (i = 0; i < line_ctrl_pkg::LINES; i++)
        begin : g_line
            logic raw_r;
            logic prev_r;
            logic lvl_r;
            logic lvl_nxt;
            // filter: a level must hold two samples to pass
            always_comb
            begin
                if (!lif.filt_en[i] || (raw_r == prev_r))
                    lvl_nxt = raw_r;
                else
                    lvl_nxt = lvl_r;
            end
            // sampling stops with the gated clock, level stays frozen
            always_ff @(posedge lif.clk)
            begin
                if (!lif.rst_n)
                begin
                    raw_r <= 1'b0;
                    prev_r <= 1'b0;
                    lvl_r <= 1'b0;
                end
                else if (lif.ce && lif.sample_en)
                begin
                    raw_r <= lif.pin_in[i];
                    prev_r <= raw_r;
                    lvl_r <= lvl_nxt;
                end
            end
            assign lif.level[i] = lvl_r;
            // new level against last cycle's level
            assign lif.change[i] = lif.ce && lif.sample_en
                                   && (lvl_nxt != lvl_r);
        end
    endgenerate
endmodule // line_sampler
`default_nettype wire

// ---- src/line_controller.sv ----
// module: programmable i/o line controller with an axi4-lite slave
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module line_controller
#(
    parameter logic [31:0] HAS_PERIPH = line_ctrl_pkg::RST_HAS_PERIPH,
    parameter logic [31:0] OWN_RESET  = line_ctrl_pkg::RST_OWN,
    parameter int unsigned IRQ_SOURCE = line_ctrl_pkg::IRQ_SRC_DEF
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        periph_clk_en,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] pad_in,
    output logic [31:0]      pad_out,
    output logic [31:0]      pad_oe_n,
    output logic [31:0]      pullup_en,
    input  wire logic [31:0] periph_a_out,
    input  wire logic [31:0] periph_a_oe,
    input  wire logic [31:0] periph_b_out,
    input  wire logic [31:0] periph_b_oe,
    output logic [31:0]      periph_in,
    output logic             irq
);
    logic        aw_v_r;
    logic [7:0]  aw_addr_r;
    logic        w_v_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        do_wr;
    logic        do_rd;
    logic [31:0] wdm;
    logic        wr_known;
    logic [31:0] own_r;
    logic [31:0] oe_r;
    logic [31:0] flt_r;
    logic [31:0] od_r;
    logic [31:0] ie_r;
    logic [31:0] isr_r;
    logic [31:0] md_r;
    logic [31:0] pu_r;
    logic [31:0] sel_r;
    logic [31:0] ow_r;
    logic        clk_on_r;
    logic [31:0] rd_nxt;
    logic        rd_ok;
    logic [31:0] drv_val;
    logic [31:0] drv_en;
    line_if      lif ();

    // write data bits whose byte lane is strobed
    assign wdm = w_data_r & {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                             {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

    // strobed bits of a write to one offset, zero otherwise
    function automatic logic [31:0] hit(input logic [7:0] off);
        hit = (do_wr && (aw_addr_r == off)) ? wdm : line_ctrl_pkg::RST_ZERO;
    endfunction

    // address and data are held until both are here, in either order
    assign s_axi_awready = !aw_v_r && !bvalid_r;
    assign s_axi_wready = !w_v_r && !bvalid_r;
    assign do_wr = aw_v_r && w_v_r && !bvalid_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_v_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_v_r <= 1'b0;
            w_data_r <= line_ctrl_pkg::RST_ZERO;
            w_strb_r <= 4'h0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_v_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            else if (do_wr)
                aw_v_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_v_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            else if (do_wr)
                w_v_r <= 1'b0;
        end
    end

    // writable offsets; status and read-only ones answer slverr
    always_comb
    begin
        unique case (aw_addr_r)
            line_ctrl_pkg::OFF_OWN_EN, line_ctrl_pkg::OFF_OWN_DIS,
            line_ctrl_pkg::OFF_OE_EN, line_ctrl_pkg::OFF_OE_DIS,
            line_ctrl_pkg::OFF_FLT_EN, line_ctrl_pkg::OFF_FLT_DIS,
            line_ctrl_pkg::OFF_OUT_SET, line_ctrl_pkg::OFF_OUT_CLR,
            line_ctrl_pkg::OFF_OUT_DATA, line_ctrl_pkg::OFF_CHG_EN,
            line_ctrl_pkg::OFF_CHG_DIS, line_ctrl_pkg::OFF_MD_EN,
            line_ctrl_pkg::OFF_MD_DIS, line_ctrl_pkg::OFF_PU_DIS,
            line_ctrl_pkg::OFF_PU_EN, line_ctrl_pkg::OFF_SEL_A,
            line_ctrl_pkg::OFF_SEL_B, line_ctrl_pkg::OFF_OW_EN,
            line_ctrl_pkg::OFF_OW_DIS: wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= line_ctrl_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (do_wr)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? line_ctrl_pkg::RESP_OKAY
                                    : line_ctrl_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // set/clear configuration bits; writes need no peripheral clock
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            own_r <= OWN_RESET | ~HAS_PERIPH;
            oe_r <= line_ctrl_pkg::RST_ZERO;
            flt_r <= line_ctrl_pkg::RST_ZERO;
            ow_r <= line_ctrl_pkg::RST_ZERO; // direct-write mode starts off
            ie_r <= line_ctrl_pkg::RST_ZERO;
            md_r <= line_ctrl_pkg::RST_ZERO;
            pu_r <= line_ctrl_pkg::RST_ZERO; // all pull-ups on
            sel_r <= line_ctrl_pkg::RST_ZERO;
        end
        else if (ce)
        begin
            own_r <= ((own_r | hit(line_ctrl_pkg::OFF_OWN_EN))
                     & ~hit(line_ctrl_pkg::OFF_OWN_DIS)) | ~HAS_PERIPH;
            oe_r <= (oe_r | hit(line_ctrl_pkg::OFF_OE_EN))
                    & ~hit(line_ctrl_pkg::OFF_OE_DIS);
            flt_r <= (flt_r | hit(line_ctrl_pkg::OFF_FLT_EN))
                     & ~hit(line_ctrl_pkg::OFF_FLT_DIS);
            ow_r <= (ow_r | hit(line_ctrl_pkg::OFF_OW_EN))
                    & ~hit(line_ctrl_pkg::OFF_OW_DIS);
            ie_r <= (ie_r | hit(line_ctrl_pkg::OFF_CHG_EN))
                    & ~hit(line_ctrl_pkg::OFF_CHG_DIS);
            md_r <= (md_r | hit(line_ctrl_pkg::OFF_MD_EN))
                    & ~hit(line_ctrl_pkg::OFF_MD_DIS);
            pu_r <= (pu_r | hit(line_ctrl_pkg::OFF_PU_DIS))
                    & ~hit(line_ctrl_pkg::OFF_PU_EN);
            sel_r <= (sel_r | hit(line_ctrl_pkg::OFF_SEL_B))
                     & ~hit(line_ctrl_pkg::OFF_SEL_A);
        end
    end

    // output data: set/clear, or one masked direct write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            od_r <= line_ctrl_pkg::RST_ZERO;
        else if (ce)
        begin
            if (do_wr && (aw_addr_r == line_ctrl_pkg::OFF_OUT_DATA))
                od_r <= (od_r & ~ow_r) | (w_data_r & ow_r);
            else
                od_r <= (od_r | hit(line_ctrl_pkg::OFF_OUT_SET))
                        & ~hit(line_ctrl_pkg::OFF_OUT_CLR);
        end
    end

    // clock gate state, off until the power manager enables it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            clk_on_r <= 1'b0;
        else if (ce)
            clk_on_r <= periph_clk_en;
    end

    // sampler only runs while the peripheral clock is on
    assign lif.clk = aclk;
    assign lif.rst_n = aresetn;
    assign lif.ce = ce;
    assign lif.sample_en = clk_on_r;
    assign lif.pin_in = pad_in;
    assign lif.filt_en = flt_r;
    line_sampler u_sampler (
        .lif (lif.sampler)
    );

    // change flags: reading clears, a new change in that cycle wins
    assign do_rd = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            isr_r <= line_ctrl_pkg::RST_ZERO;
        else if (ce)
        begin
            if (do_rd && (s_axi_araddr == line_ctrl_pkg::OFF_CHG_ST))
                isr_r <= lif.change;
            else
                isr_r <= isr_r | lif.change;
        end
    end

    // interrupt never fires with the clock gated
    assign irq = clk_on_r && ((isr_r & ie_r) != line_ctrl_pkg::RST_ZERO);

    // read mux; unmapped offsets read zero with slverr
    always_comb
    begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            line_ctrl_pkg::OFF_OWN_ST:   rd_nxt = own_r;
            line_ctrl_pkg::OFF_OE_ST:    rd_nxt = oe_r;
            line_ctrl_pkg::OFF_FLT_ST:   rd_nxt = flt_r;
            line_ctrl_pkg::OFF_OUT_DATA: rd_nxt = od_r;
            line_ctrl_pkg::OFF_PIN_ST:   rd_nxt = lif.level;
            line_ctrl_pkg::OFF_CHG_MASK: rd_nxt = ie_r;
            line_ctrl_pkg::OFF_CHG_ST:   rd_nxt = isr_r;
            line_ctrl_pkg::OFF_MD_ST:    rd_nxt = md_r;
            line_ctrl_pkg::OFF_PU_ST:    rd_nxt = pu_r;
            line_ctrl_pkg::OFF_SEL_ST:   rd_nxt = sel_r;
            line_ctrl_pkg::OFF_OW_ST:    rd_nxt = ow_r;
            default:
            begin
                rd_nxt = line_ctrl_pkg::RST_ZERO;
                rd_ok = 1'b0;
            end
        endcase
    end

    // read answer one cycle after the address is taken
    assign s_axi_arready = !rvalid_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= line_ctrl_pkg::RST_ZERO;
            rresp_r <= line_ctrl_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (do_rd)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_nxt;
                rresp_r <= rd_ok ? line_ctrl_pkg::RESP_OKAY
                                 : line_ctrl_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // pad drive: owner picks controller or peripheral a/b
    assign drv_val = (own_r & od_r) | (~own_r & ((sel_r & periph_b_out)
                     | (~sel_r & periph_a_out)));
    assign drv_en = (own_r & oe_r) | (~own_r & ((sel_r & periph_b_oe)
                    | (~sel_r & periph_a_oe)));

    // multi-drive only pulls low, high comes from a pull-up
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_out <= line_ctrl_pkg::RST_ZERO;
            pad_oe_n <= ~line_ctrl_pkg::RST_ZERO;
            pullup_en <= ~line_ctrl_pkg::RST_ZERO;
        end
        else if (ce)
        begin
            pad_out <= drv_val & ~md_r;
            pad_oe_n <= ~(drv_en & (~md_r | ~drv_val));
            pullup_en <= ~pu_r;
        end
    end

    // peripherals see the raw pin; change detection uses the sampled, filtered level
    assign periph_in = pad_in;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_irq_source_range: assert property (
        IRQ_SOURCE >= line_ctrl_pkg::IRQ_SRC_MIN
        && IRQ_SOURCE <= line_ctrl_pkg::IRQ_SRC_MAX)
        else $error("interrupt source outside user range");
    a_fixed_owner: assert property (
        (own_r | HAS_PERIPH) == 32'hffff_ffff)
        else $error("line without peripheral left controller");
    a_irq_gated: assert property (
        ce && !periph_clk_en |=> !irq)
        else $error("interrupt raised with clock gated");
    a_masked_write: assert property (
        ce && do_wr && aw_addr_r == line_ctrl_pkg::OFF_OUT_DATA
        |=> ((od_r ^ $past(od_r)) & ~$past(ow_r)) == 32'h0000_0000)
        else $error("direct write touched masked output bit");
    a_pin_frozen: assert property (
        !clk_on_r |=> $stable(lif.level))
        else $error("pin level moved with clock gated");
    a_periph_input: assert property (
        periph_in == pad_in)
        else $error("peripheral input differs from pin");
    a_change_sticky: assert property (
        ce && lif.change != 32'h0000_0000
        |=> ($past(lif.change) & ~isr_r) == 32'h0000_0000)
        else $error("line change not flagged");
    a_write_gated: assert property (
        ce && !clk_on_r && do_wr && aw_addr_r == line_ctrl_pkg::OFF_OE_EN
        |=> (oe_r & $past(wdm)) == $past(wdm))
        else $error("write lost while clock gated");
    a_gpio_drive: assert property (
        ce && own_r[0] && oe_r[0] && !md_r[0]
        |=> !pad_oe_n[0] && pad_out[0] == $past(od_r[0]))
        else $error("owned output line not driven");
    a_write_resp: assert property (
        ce && do_wr |=> s_axi_bvalid ##0 !s_axi_awready)
        else $error("write answer missing");

    c_direct_write: cover property (
        ce && do_wr && aw_addr_r == line_ctrl_pkg::OFF_OUT_DATA);
    c_change_irq: cover property (!irq ##1 irq);
    c_read_clear: cover property (
        do_rd && s_axi_araddr == line_ctrl_pkg::OFF_CHG_ST && isr_r != 0);
endmodule // line_controller
`default_nettype wire

// ---- bench/pin_world.sv ----
// pin model: pad levels from every driver plus two fixed peripherals
`timescale 1ns/1ps
`default_nettype none
module pin_world
(
    input  wire logic        aclk,
    input  wire logic [31:0] pad_out,
    input  wire logic [31:0] pad_oe_n,
    input  wire logic [31:0] pullup_en,
    input  wire logic [31:0] ext_drv,
    input  wire logic [31:0] ext_lvl,
    output logic [31:0]      pad_in,
    output logic [31:0]      periph_a_out,
    output logic [31:0]      periph_a_oe,
    output logic [31:0]      periph_b_out,
    output logic [31:0]      periph_b_oe
);
    logic [31:0] last_r;
    // peripheral a drives low and b drives high, so a swap shows
    assign periph_a_out = 32'h0;
    assign periph_a_oe = 32'hffff_ffff;
    assign periph_b_out = 32'hffff_ffff;
    assign periph_b_oe = 32'hffff_ffff;
    // a low drive wins; a floating line reads high with its pull-up on, flips without it
    assign pad_in = (~pad_oe_n & pad_out & (~ext_drv | ext_lvl))
        | (pad_oe_n & ext_drv & ext_lvl)
        | (pad_oe_n & ~ext_drv & (pullup_en | ~last_r));
    always_ff @(posedge aclk)
        last_r <= pad_in;
endmodule // pin_world
`default_nettype wire

// ---- bench/tb.sv ----
// testbench: bus, pin, filter and change tests of the line controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, irq;
    logic        periph_clk_en = 1'b0, s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, periph_in;
    logic [31:0] pad_in, pad_out, pad_oe_n, pullup_en;
    logic [31:0] periph_a_out, periph_a_oe, periph_b_out, periph_b_oe;
    logic [31:0] ext_drv = 32'h0, ext_lvl = 32'h0;
    int          fails = 0, total_checks = 0;
    // line 31 has no peripheral behind it
    line_controller #(.HAS_PERIPH(32'h7fff_ffff)) dut_u
    (
        .aclk, .aresetn, .ce, .periph_clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out,
        .pad_oe_n, .pullup_en, .periph_a_out, .periph_a_oe, .periph_b_out,
        .periph_b_oe, .periph_in, .irq
    );
    pin_world pw_u
    (
        .aclk, .pad_out, .pad_oe_n, .pullup_en, .ext_drv, .ext_lvl, .pad_in,
        .periph_a_out, .periph_a_oe, .periph_b_out, .periph_b_oe
    );
    initial
        forever #2 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // ready is sampled mid-cycle, where it is already settled
    task automatic acc(input bit w, input logic [7:0] a,
        input logic [31:0] d, input logic [1:0] er, input bit ck);
        logic        ah, wh, b;
        logic [31:0] q;
        logic [1:0]  r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do
        begin
            @(negedge aclk);
            ah = w ? s_axi_awready : s_axi_arready;
            wh = s_axi_wready;
            b = w ? s_axi_bvalid : s_axi_rvalid;
            r = w ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge aclk);
            if (ah && w) s_axi_awvalid <= 1'b0;
            if (ah && !w) s_axi_arvalid <= 1'b0;
            if (wh && w) s_axi_wvalid <= 1'b0;
        end
        while (!b);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!w && ck) chk($sformatf("rdata %h", a), d, q);
        chk("resp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = line_ctrl_pkg::RESP_OKAY);
        acc(1'b1, a, d, er, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input bit ck = 1'b1, input logic [1:0] er = line_ctrl_pkg::RESP_OKAY);
        acc(1'b0, a, e, er, ck);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic drv(input logic [31:0] l);
        @(posedge aclk);
        ext_drv <= 32'h3010_0000;
        ext_lvl <= l;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the tests take about 200 cycles
    initial
    begin
        repeat (4000) @(posedge aclk);
        fails++;
        test_done;
    end
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(line_ctrl_pkg::OFF_OWN_ST, 32'hffff_ffff);
        rd(line_ctrl_pkg::OFF_PU_ST, 32'h0);
        rd(line_ctrl_pkg::OFF_OW_ST, 32'h0);
        wr(line_ctrl_pkg::OFF_CHG_EN, 32'h3010_0000);
        rd(line_ctrl_pkg::OFF_CHG_MASK, 32'h3010_0000);
        drv(32'h3000_0000);
        cyc(5);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test gated done");
        // software turns the clock on before reading inputs
        @(posedge aclk);
        periph_clk_en <= 1'b1;
        cyc(5);
        rd(line_ctrl_pkg::OFF_CHG_ST, 32'h0, 1'b0);
        rd(line_ctrl_pkg::OFF_PIN_ST, 32'hffef_ffff);
        drv(32'h3010_0000);
        cyc(4);
        chk("irq", 32'h1, {31'h0, irq});
        rd(line_ctrl_pkg::OFF_CHG_ST, 32'h0010_0000);
        periph_clk_en <= 1'b0;
        cyc(3);
        drv(32'h3000_0000);
        cyc(4);
        chk("irq", 32'h0, {31'h0, irq});
        chk("periph_in", 32'hffef_ffff, periph_in);
        rd(line_ctrl_pkg::OFF_PIN_ST, 32'hffff_ffff);
        periph_clk_en <= 1'b1;
        wr(line_ctrl_pkg::OFF_FLT_EN, 32'h1000_0000);
        cyc(5);
        rd(line_ctrl_pkg::OFF_CHG_ST, 32'h0, 1'b0);
        drv(32'h0);
        drv(32'h3000_0000);
        cyc(5);
        rd(line_ctrl_pkg::OFF_CHG_ST, 32'h2000_0000);
        $display("test change done");
        wr(line_ctrl_pkg::OFF_OE_EN, 32'h0000_00ff);
        wr(line_ctrl_pkg::OFF_OE_DIS, 32'h0000_000f);
        wr(line_ctrl_pkg::OFF_OE_EN, 32'h0);
        rd(line_ctrl_pkg::OFF_OE_ST, 32'h0000_00f0);
        wr(line_ctrl_pkg::OFF_OUT_SET, 32'h0000_00ff);
        wr(line_ctrl_pkg::OFF_OUT_CLR, 32'h0000_0033);
        cyc(3);
        chk("pad_oe_n", 32'hffff_ff0f, pad_oe_n);
        rd(line_ctrl_pkg::OFF_PIN_ST, 32'hffef_ffcf);
        wr(line_ctrl_pkg::OFF_OW_EN, 32'h0000_00f0);
        wr(line_ctrl_pkg::OFF_OUT_DATA, 32'hffff_ff55);
        rd(line_ctrl_pkg::OFF_OUT_DATA, 32'h0000_005c);
        cyc(2);
        chk("pad_out", 32'h0000_005c, pad_out);
        $display("test output done");
        wr(line_ctrl_pkg::OFF_OWN_DIS, 32'h8003_0000);
        wr(line_ctrl_pkg::OFF_SEL_B, 32'h0002_0000);
        rd(line_ctrl_pkg::OFF_OWN_ST, 32'hfffc_ffff);
        rd(line_ctrl_pkg::OFF_SEL_ST, 32'h0002_0000);
        wr(line_ctrl_pkg::OFF_MD_EN, 32'h0100_0000);
        wr(line_ctrl_pkg::OFF_OE_EN, 32'h0100_0000);
        wr(line_ctrl_pkg::OFF_OUT_SET, 32'h0100_0000);
        cyc(2);
        chk("pad_oe_n", 32'hfffc_ff0f, pad_oe_n);
        wr(line_ctrl_pkg::OFF_OUT_CLR, 32'h0100_0000);
        wr(line_ctrl_pkg::OFF_PU_DIS, 32'h0100_0000);
        cyc(2);
        chk("pad_oe_n", 32'hfefc_ff0f, pad_oe_n);
        chk("pad_out", 32'h0002_005c, pad_out);
        chk("pullup_en", 32'hfeff_ffff, pullup_en);
        $display("test drive done");
        // clock enable low freezes change detection, which resumes later
        @(posedge aclk);
        ce <= 1'b0;
        drv(32'h0);
        cyc(3);
        chk("irq", 32'h0, {31'h0, irq});
        @(posedge aclk);
        ce <= 1'b1;
        cyc(3);
        chk("irq", 32'h1, {31'h0, irq});
        $display("test freeze done");
        rd(8'hfc, 32'h0, 1'b1, line_ctrl_pkg::RESP_SLVERR);
        wr(line_ctrl_pkg::OFF_PIN_ST, 32'h0,
           line_ctrl_pkg::RESP_SLVERR);
        $display("test errors done");
        test_done;
    end
endmodule // tb
`default_nettype wire
